/* common/airs_pkg.sv */
// package for the converter input and reference select block
// assumes one 40 MHz system clock and a plain register port
package airs_pkg;

    localparam int NUM_SLOTS = 8;
    localparam int SLOT_W = 3;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int CODE_W = 5;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_SLOT_CTRL = 5'h00; // 00..07 slot control
    localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h08; // 08..0F results
    localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_CLK_CFG = 5'h11;
    localparam logic [ADDR_W-1:0] OFS_TRIG_CFG = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h13;

    // slot control fields
    localparam int CODE_LSB = 0;
    localparam int DIFF_BIT = 5;
    localparam logic [7:0] SLOT_RESET = 8'h1F;

    // status fields
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_RSVD_BIT = 3;
    localparam int STAT_SLOT_LSB = 4;

    // reference codes
    localparam logic [1:0] REF_PAD = 2'h0;
    localparam logic [1:0] REF_INTERNAL = 2'h1;
    localparam logic [1:0] REF_BANDGAP = 2'h2;
    localparam logic [1:0] REF_RESERVED = 2'h3;

    // conversion clock codes
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;

    // channel codes
    localparam logic [4:0] CH_DIFF_LAST = 5'h03;
    localparam logic [4:0] CH_SE_LAST = 5'h0B;
    localparam logic [4:0] CH_CMP_OUT = 5'h0E;
    localparam logic [4:0] CH_AMP_ONE = 5'h0F;
    localparam logic [4:0] CH_AMP_TWO = 5'h10;
    localparam logic [4:0] CH_DAC = 5'h11;
    localparam logic [4:0] CH_REF_OUT = 5'h18;
    localparam logic [4:0] CH_TEMP = 5'h1A;
    localparam logic [4:0] CH_BANDGAP = 5'h1B;
    localparam logic [4:0] CH_HIGH_REF = 5'h1D;
    localparam logic [4:0] CH_LOW_REF = 5'h1E;
    localparam logic [4:0] CH_DISABLED = 5'h1F;

    // decoded input source, binary-coded id on the analog mux
    localparam logic [4:0] SRC_EXT0 = 5'h00; // 00..0B external pins / pairs
    localparam logic [4:0] SRC_CMP = 5'h10;
    localparam logic [4:0] SRC_AMP1 = 5'h11;
    localparam logic [4:0] SRC_AMP2 = 5'h12;
    localparam logic [4:0] SRC_DAC = 5'h13;
    localparam logic [4:0] SRC_REFO = 5'h14;
    localparam logic [4:0] SRC_TEMP = 5'h15;
    localparam logic [4:0] SRC_BG = 5'h16;
    localparam logic [4:0] SRC_VH = 5'h17;
    localparam logic [4:0] SRC_VL = 5'h18;
    localparam logic [4:0] SRC_NONE = 5'h1F;

    localparam int CONV_CYCLES = 16;
    localparam logic [4:0] CONV_LEN = 5'h10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } airs_state_t;
endpackage : airs_pkg

/* common/airs_sel_if.sv */
// selection bundle between the control top and the channel decoder
// assumes both ends share the system clock
`timescale 1ns/1ps
`default_nettype none
interface airs_sel_if;
    logic [4:0] code;
    logic diffMode;
    logic [4:0] source;
    logic diffPair;
    logic triampPair;
    logic reservedCode;
    logic disabled;
    modport ctrl (output code, output diffMode, input source, input diffPair,
        input triampPair, input reservedCode, input disabled);
    modport dec (input code, input diffMode, output source, output diffPair,
        output triampPair, output reservedCode, output disabled);
endinterface : airs_sel_if
`default_nettype wire

/* verilog/airs_channel_decode.sv */
// channel code decoder for differential and single-ended maps
// assumes code and mode come from the active slot
`timescale 1ns/1ps
`default_nettype none
module airs_channel_decode
    import airs_pkg::*;
(
    // selection bundle
    airs_sel_if.dec sel
);
    always_comb begin
        sel.source = SRC_NONE;
        sel.diffPair = 1'b0;
        sel.triampPair = 1'b0;
        sel.reservedCode = 1'b0;
        sel.disabled = 1'b0;
        if (sel.diffMode) begin
            if (sel.code <= CH_DIFF_LAST) begin
                sel.source = 5'(SRC_EXT0 + sel.code);
                sel.diffPair = 1'b1;
                sel.triampPair = sel.code[1];
            end else begin
                case (sel.code)
                    CH_TEMP: sel.source = SRC_TEMP;
                    CH_BANDGAP: sel.source = SRC_BG;
                    CH_HIGH_REF: sel.source = SRC_VH;
                    CH_DISABLED: sel.disabled = 1'b1;
                    default: sel.reservedCode = 1'b1;
                endcase
            end
        end else begin
            if (sel.code <= CH_SE_LAST) begin
                sel.source = 5'(SRC_EXT0 + sel.code);
            end else begin
                case (sel.code)
                    CH_CMP_OUT: sel.source = SRC_CMP;
                    CH_AMP_ONE: sel.source = SRC_AMP1;
                    CH_AMP_TWO: sel.source = SRC_AMP2;
                    CH_DAC: sel.source = SRC_DAC;
                    CH_REF_OUT: sel.source = SRC_REFO;
                    CH_TEMP: sel.source = SRC_TEMP;
                    CH_BANDGAP: sel.source = SRC_BG;
                    CH_HIGH_REF: sel.source = SRC_VH;
                    CH_LOW_REF: sel.source = SRC_VL;
                    CH_DISABLED: sel.disabled = 1'b1;
                    default: sel.reservedCode = 1'b1;
                endcase
            end
        end
    end
endmodule : airs_channel_decode
`default_nettype wire

/* verilog/airs_sync2.sv */
// two flip-flop synchroniser for one level
// assumes input is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module airs_sync2 (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // level
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : airs_sync2
`default_nettype wire

/* verilog/airs_input_ref_select.sv */
// converter configuration: reference, channel, slots, triggers, clock select
// assumes trigger pins and alternate clock arrive asynchronously
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module airs_input_ref_select
    import airs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // hardware triggers and conversion clocks
    input wire logic todTrigger,
    input wire logic pdbTrigger,
    input wire logic [SLOT_W-1:0] pdbSlotSelect,
    input wire logic localAsyncConvClock,
    input wire logic clockgenExternalRefClock,
    // converter core side
    input wire logic [DATA_W-1:0] coreResult,
    output logic [1:0] referenceSource,
    output logic [4:0] inputSource,
    output logic inputDifferential,
    output logic triampRouted,
    output logic convBusy,
    output logic convClockTick,
    output logic [SLOT_W-1:0] activeSlot
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] slotCtrl_q [NUM_SLOTS];
    logic [7:0] slotCtrl_d [NUM_SLOTS];
    logic [DATA_W-1:0] result_q [NUM_SLOTS];
    logic [DATA_W-1:0] result_d [NUM_SLOTS];
    logic [1:0] reference_source_select_q, reference_source_select_d;
    logic [1:0] clkSel_q, clkSel_d;
    logic trigSrc_q, trigSrc_d;
    logic hwTrigEn_q, hwTrigEn_d;
    logic reservedHit_q, reservedHit_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [SLOT_W-1:0] slot_q, slot_d;
    logic [SLOT_W-1:0] preSlot_q, preSlot_d;
    logic [4:0] count_q, count_d;
    logic div_q, div_d;
    logic tick_q, tick_d;
    logic [1:0] refOut_q, refOut_d;
    logic [4:0] srcOut_q, srcOut_d;
    logic diffOut_q, diffOut_d;
    logic triOut_q, triOut_d;
    logic trigPrev_q, trigPrev_d;
    logic asyncPrev_q, asyncPrev_d;
    logic altPrev_q, altPrev_d;
    airs_state_t state_q, state_d;

    ////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic todSync, pdbSync, asyncSync, altSync;
    airs_sync2 uTodSync (.clk_sys(clk_sys), .rstn(rstn), .din(todTrigger), .dout(todSync));
    airs_sync2 uPdbSync (.clk_sys(clk_sys), .rstn(rstn), .din(pdbTrigger), .dout(pdbSync));
    airs_sync2 uAsyncSync (.clk_sys(clk_sys), .rstn(rstn), .din(localAsyncConvClock),
        .dout(asyncSync));
    airs_sync2 uAltSync (.clk_sys(clk_sys), .rstn(rstn), .din(clockgenExternalRefClock),
        .dout(altSync));

    logic [SLOT_W-1:0] slotSelSync;
    genvar gi;
    generate
        for (gi = 0; gi < SLOT_W; gi++) begin : gSlotSync
            airs_sync2 uSlot (.clk_sys(clk_sys), .rstn(rstn), .din(pdbSlotSelect[gi]),
                .dout(slotSelSync[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // channel decode of the active slot
    airs_sel_if sel ();
    assign sel.code = slotCtrl_q[slot_q][CODE_LSB +: CODE_W];
    assign sel.diffMode = slotCtrl_q[slot_q][DIFF_BIT];
    airs_channel_decode uDecode (.sel(sel));

    // status word for the read mux
    logic [DATA_W-1:0] statusWord;
    always_comb begin
        statusWord = '0;
        statusWord[STAT_SLOT_LSB +: SLOT_W] = slot_q;
        statusWord[STAT_RSVD_BIT] = reservedHit_q;
        statusWord[STAT_DONE_BIT] = done_q;
        statusWord[STAT_BUSY_BIT] = busy_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    logic trigLevel, trigRise, swStart, clkEvent;
    logic [SLOT_W-1:0] idx;
    always_comb begin
        slotCtrl_d = slotCtrl_q;
        result_d = result_q;
        reference_source_select_d = reference_source_select_q;
        clkSel_d = clkSel_q;
        trigSrc_d = trigSrc_q;
        hwTrigEn_d = hwTrigEn_q;
        reservedHit_d = reservedHit_q;
        done_d = done_q;
        rdata_d = '0;
        slot_d = slot_q;
        preSlot_d = slotSelSync;
        count_d = count_q;
        state_d = state_q;
        swStart = 1'b0;
        idx = regAddr[SLOT_W-1:0];

        // register writes
        if (regWrite) begin
            if (regAddr < OFS_RESULT) begin
                slotCtrl_d[idx] = regWdata[7:0];
                swStart = !hwTrigEn_q && (idx == '0);
            end else if (regAddr == OFS_CTRL_TWO) begin
                reference_source_select_d = regWdata[1:0];
                hwTrigEn_d = regWdata[6];
            end else if (regAddr == OFS_CLK_CFG) begin
                clkSel_d = regWdata[1:0];
            end else if (regAddr == OFS_TRIG_CFG) begin
                trigSrc_d = regWdata[0];
            end
        end

        // register reads
        if (regRead) begin
            if (regAddr < OFS_RESULT) begin
                rdata_d = {8'h00, slotCtrl_q[idx]};
            end else if (regAddr < OFS_CTRL_TWO) begin
                rdata_d = result_q[idx];
                if (idx == slot_q) begin
                    done_d = 1'b0;
                end
            end else if (regAddr == OFS_CTRL_TWO) begin
                rdata_d = {9'h000, hwTrigEn_q, 4'h0, reference_source_select_q};
            end else if (regAddr == OFS_CLK_CFG) begin
                rdata_d = {14'h0000, clkSel_q};
            end else if (regAddr == OFS_TRIG_CFG) begin
                rdata_d = {15'h0000, trigSrc_q};
            end else if (regAddr == OFS_STATUS) begin
                rdata_d = statusWord;
            end
        end

        // hardware trigger source and edge
        trigLevel = trigSrc_q ? pdbSync : todSync;
        trigPrev_d = trigLevel;
        trigRise = trigLevel && !trigPrev_q && hwTrigEn_q;

        // conversion clock tick
        div_d = !div_q;
        asyncPrev_d = asyncSync;
        altPrev_d = altSync;
        case (clkSel_q)
            CLK_BUS: clkEvent = 1'b1;
            CLK_BUS_DIV2: clkEvent = div_q;
            CLK_ALT: clkEvent = altSync && !altPrev_q;
            CLK_ASYNC: clkEvent = asyncSync && !asyncPrev_q;
            default: clkEvent = 1'b1;
        endcase
        tick_d = clkEvent;

        case (state_q)
            ST_IDLE: begin
                if (trigRise) begin
                    slot_d = preSlot_q;
                    count_d = '0;
                    state_d = ST_CONV;
                end else if (swStart) begin
                    slot_d = '0;
                    count_d = '0;
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sel.disabled) begin
                    state_d = ST_IDLE;
                end else if (clkEvent) begin
                    count_d = 5'(count_q + 5'h01);
                    if (count_q == CONV_LEN - 5'h01) begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                result_d[slot_q] = coreResult;
                reservedHit_d = sel.reservedCode;
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase

        busy_d = (state_d != ST_IDLE);

        // outputs
        case (reference_source_select_q)
            REF_INTERNAL: refOut_d = REF_INTERNAL;
            REF_BANDGAP: refOut_d = REF_BANDGAP;
            REF_RESERVED: refOut_d = REF_PAD;
            default: refOut_d = REF_PAD;
        endcase
        srcOut_d = sel.source;
        diffOut_d = sel.diffPair;
        triOut_d = sel.triampPair;
    end

    ////////////////////////////////////////////////////////////////////////
    // slot control array
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slotCtrl_q[i] <= SLOT_RESET;
            end
        end else begin
            slotCtrl_q <= slotCtrl_d;
        end
    end

    // configuration bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reference_source_select_q <= REF_PAD;
            clkSel_q <= CLK_BUS;
            trigSrc_q <= 1'b0;
            hwTrigEn_q <= 1'b0;
        end else begin
            reference_source_select_q <= reference_source_select_d;
            clkSel_q <= clkSel_d;
            trigSrc_q <= trigSrc_d;
            hwTrigEn_q <= hwTrigEn_d;
        end
    end

    // conversion sequencing and results
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_SLOTS; i++) begin
                result_q[i] <= '0;
            end
            reservedHit_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            slot_q <= '0;
            preSlot_q <= '0;
            count_q <= '0;
            state_q <= ST_IDLE;
        end else begin
            result_q <= result_d;
            reservedHit_q <= reservedHit_d;
            done_q <= done_d;
            busy_q <= busy_d;
            slot_q <= slot_d;
            preSlot_q <= preSlot_d;
            count_q <= count_d;
            state_q <= state_d;
        end
    end

    // clock divider and edge detectors
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_q <= 1'b0;
            tick_q <= 1'b0;
            trigPrev_q <= 1'b0;
            asyncPrev_q <= 1'b0;
            altPrev_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
            trigPrev_q <= trigPrev_d;
            asyncPrev_q <= asyncPrev_d;
            altPrev_q <= altPrev_d;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
            refOut_q <= REF_PAD;
            srcOut_q <= SRC_NONE;
            diffOut_q <= 1'b0;
            triOut_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            refOut_q <= refOut_d;
            srcOut_q <= srcOut_d;
            diffOut_q <= diffOut_d;
            triOut_q <= triOut_d;
        end
    end

    assign regRdata = rdata_q;
    assign referenceSource = refOut_q;
    assign inputSource = srcOut_q;
    assign inputDifferential = diffOut_q;
    assign triampRouted = triOut_q;
    assign convClockTick = tick_q;
    assign activeSlot = slot_q;
    assign convBusy = busy_q;
endmodule : airs_input_ref_select
`default_nettype wire

/* sim/airs_input_ref_select_monitor.sv */
// checker of the converter configuration block at its ports
// assumes it is bound to airs_input_ref_select and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module airs_input_ref_select_monitor
    import airs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdata,
    // triggers and clocks
    input wire logic todTrigger,
    input wire logic pdbTrigger,
    input wire logic [SLOT_W-1:0] pdbSlotSelect,
    input wire logic localAsyncConvClock,
    input wire logic clockgenExternalRefClock,
    // converter core side
    input wire logic [DATA_W-1:0] coreResult,
    input wire logic [1:0] referenceSource,
    input wire logic [4:0] inputSource,
    input wire logic inputDifferential,
    input wire logic triampRouted,
    input wire logic convBusy,
    input wire logic convClockTick,
    input wire logic [SLOT_W-1:0] activeSlot
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ref_decode;
        logic [1:0] c;
        (regWrite && regAddr == OFS_CTRL_TWO, c = regWdata[1:0])
            |-> ##2 referenceSource == ((c == REF_RESERVED) ? REF_PAD : c);
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("reference source wrong");
    property p_ref_never_reserved;
        referenceSource != REF_RESERVED;
    endproperty
    a_ref_never_reserved: assert property (p_ref_never_reserved)
        else $error("reserved reference driven");
    property p_transimpedance_amplifier;
        triampRouted |-> inputDifferential && (inputSource == 5'h02 || inputSource == 5'h03);
    endproperty
    a_transimpedance_amplifier: assert property (p_transimpedance_amplifier) else $error("amplifier routing wrong");
    property p_diff_src;
        inputDifferential |-> inputSource <= CH_DIFF_LAST;
    endproperty
    a_diff_src: assert property (p_diff_src) else $error("differential source out of range");
    property p_src_range;
        inputSource <= 5'h0B || (inputSource >= SRC_CMP && inputSource <= SRC_VL)
            || inputSource == SRC_NONE;
    endproperty
    a_src_range: assert property (p_src_range) else $error("source id not in map");
    property p_src_none;
        inputSource == SRC_NONE |-> !inputDifferential && !triampRouted;
    endproperty
    a_src_none: assert property (p_src_none) else $error("disabled source flagged");
    property p_rdata_idle;
        !regRead |=> regRdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
    property p_unmapped;
        regRead && regAddr > OFS_STATUS |=> regRdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_slot_hold;
        convBusy [*3] |-> $stable(activeSlot);
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot changed mid conversion");
    c_busy: cover property ($rose(convBusy));
    c_transimpedance_amplifier: cover property (triampRouted);
    c_bandgap: cover property (referenceSource == REF_BANDGAP);
endmodule : airs_input_ref_select_monitor
bind airs_input_ref_select airs_input_ref_select_monitor mon_i (.clk_sys(clk_sys),
    .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .todTrigger(todTrigger),
    .pdbTrigger(pdbTrigger), .pdbSlotSelect(pdbSlotSelect),
    .localAsyncConvClock(localAsyncConvClock),
    .clockgenExternalRefClock(clockgenExternalRefClock), .coreResult(coreResult),
    .referenceSource(referenceSource), .inputSource(inputSource),
    .inputDifferential(inputDifferential), .triampRouted(triampRouted),
    .convBusy(convBusy), .convClockTick(convClockTick), .activeSlot(activeSlot));
`default_nettype wire

/* sim/airs_input_ref_select_test.sv */
// self-checking bench of the converter configuration block
// assumes the bound checker and a 40 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module airs_input_ref_select_test;
    import airs_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic todTrigger = 1'b0;
    logic pdbTrigger = 1'b0;
    logic [SLOT_W-1:0] pdbSlotSelect = '0;
    logic localAsyncConvClock = 1'b0;
    logic clockgenExternalRefClock = 1'b0;
    logic [DATA_W-1:0] coreResult = 16'hA5C3;
    logic [1:0] referenceSource;
    logic [4:0] inputSource;
    logic inputDifferential, triampRouted, convBusy, convClockTick;
    logic [SLOT_W-1:0] activeSlot;
    logic [7:0] cnt = 8'h00;
    int n_fail = 0;
    int tests_run = 0;
    always #12.5 clk_sys = ~clk_sys;
    // slow clocks: local async period 4 cycles, alternate period 8 cycles
    always @(posedge clk_sys) begin
        cnt <= cnt + 8'h01;
        localAsyncConvClock <= cnt[1];
        clockgenExternalRefClock <= cnt[2];
    end
    airs_input_ref_select airs_input_ref_select_i (.clk_sys(clk_sys), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .todTrigger(todTrigger), .pdbTrigger(pdbTrigger),
        .pdbSlotSelect(pdbSlotSelect), .localAsyncConvClock(localAsyncConvClock),
        .clockgenExternalRefClock(clockgenExternalRefClock), .coreResult(coreResult),
        .referenceSource(referenceSource), .inputSource(inputSource),
        .inputDifferential(inputDifferential), .triampRouted(triampRouted),
        .convBusy(convBusy), .convClockTick(convClockTick), .activeSlot(activeSlot));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // wait for busy to reach a level, returns the cycles spent
    task automatic wait_busy(input logic lvl, input int lim, output int n);
        n = 0;
        while (convBusy !== lvl && n < lim) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= lim) begin
            n_fail++;
            $display("ERROR t=%0t busy wait expired", $time);
        end
    endtask : wait_busy
    function automatic logic [4:0] exp_src(input logic d, input logic [4:0] c);
        if (d) begin
            if (c <= 5'h03) return c;
            case (c)
                5'h1A: return SRC_TEMP;
                5'h1B: return SRC_BG;
                5'h1D: return SRC_VH;
                default: return SRC_NONE;
            endcase
        end
        if (c <= 5'h0B) return c;
        case (c)
            5'h0E: return SRC_CMP;
            5'h0F: return SRC_AMP1;
            5'h10: return SRC_AMP2;
            5'h11: return SRC_DAC;
            5'h18: return SRC_REFO;
            5'h1A: return SRC_TEMP;
            5'h1B: return SRC_BG;
            5'h1D: return SRC_VH;
            5'h1E: return SRC_VL;
            default: return SRC_NONE;
        endcase
    endfunction : exp_src
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        final_report;
    end
    initial begin
        logic [15:0] d;
        int n;
        int per [4] = '{1, 2, 8, 4};
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(5'h03, d);
        `CHECK(d, 16'h001F)
        `CHECK({referenceSource, inputSource}, {REF_PAD, SRC_NONE})
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CTRL_TWO, 16'(r));
            rd(OFS_CTRL_TWO, d);
            `CHECK(d[1:0], 2'(r))
            `CHECK(referenceSource, (r == 3) ? REF_PAD : 2'(r))
        end
        rd(5'h1F, d);
        `CHECK(d, 16'h0000)
        // every code through both maps on slot zero
        for (int m = 0; m < 64; m++) begin
            wr(OFS_SLOT_CTRL, {10'h000, m[5], m[4:0]});
            repeat (3) @(posedge clk_sys);
            #1 `CHECK(inputSource, exp_src(m[5], m[4:0]))
            `CHECK(inputDifferential, m[5] && m[4:0] <= 5'h03)
            `CHECK(triampRouted, m[5] && (m[4:0] == 5'h02 || m[4:0] == 5'h03))
            wait_busy(1'b0, 100, n);
        end
        // conversion length follows the selected conversion clock
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CLK_CFG, 16'(s));
            wr(OFS_SLOT_CTRL, 16'h0001);
            wait_busy(1'b1, 20, n);
            wait_busy(1'b0, 300, n);
            `CHECK(n >= 15 * per[s] && n <= 16 * per[s] + 8, 1'b1)
            n = 0;
            repeat (8) begin
                @(posedge clk_sys);
                #1 n += int'(convClockTick);
            end
            `CHECK(n, 8 / per[s])
        end
        rd(OFS_STATUS, d);
        `CHECK(d[7:1], 7'h02)
        rd(OFS_RESULT, d);
        `CHECK(d, 16'hA5C3)
        wr(OFS_CLK_CFG, 16'h0000);
        // hardware triggers with slot preselect
        wr(OFS_CTRL_TWO, 16'h0040);
        wr(OFS_TRIG_CFG, 16'h0001);
        wr(OFS_SLOT_CTRL + 5'h05, 16'h0022);
        @(posedge clk_sys);
        pdbSlotSelect <= 3'h5;
        coreResult <= 16'h3C5A;
        todTrigger <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 `CHECK(convBusy, 1'b0)
        @(posedge clk_sys);
        todTrigger <= 1'b0;
        pdbTrigger <= 1'b1;
        wait_busy(1'b1, 20, n);
        repeat (3) @(posedge clk_sys);
        #1 `CHECK({activeSlot, triampRouted}, {3'h5, 1'b1})
        wait_busy(1'b0, 100, n);
        @(posedge clk_sys) pdbTrigger <= 1'b0;
        rd(OFS_RESULT + 5'h05, d);
        `CHECK(d, 16'h3C5A)
        wr(OFS_TRIG_CFG, 16'h0000);
        @(posedge clk_sys);
        todTrigger <= 1'b1;
        wait_busy(1'b1, 20, n);
        `CHECK({convBusy, activeSlot}, {1'b1, 3'h5})
        wait_busy(1'b0, 100, n);
        @(posedge clk_sys) todTrigger <= 1'b0;
        // eight independent slot registers
        for (int k = 0; k < 8; k++) wr(OFS_SLOT_CTRL + 5'(k), 16'(k + 8'h20));
        for (int k = 0; k < 8; k++) begin
            rd(OFS_SLOT_CTRL + 5'(k), d);
            `CHECK(d, 16'(k + 8'h20))
        end
        final_report;
    end
endmodule : airs_input_ref_select_test
`default_nettype wire
